// ==== design/ctmc_transceiver.sv ====
`timescale 1ns/1ps
module ctmc_transceiver
  import ctmc_pkg::*;
#(
  parameter int CNT_W = CTMC_CNT_W,
  parameter int EN_CYC = CTMC_EN_CYC,
  parameter int WAKE_MIN_CYC = CTMC_WAKE_MIN_CYC,
  parameter int WAKE_MAX_CYC = CTMC_WAKE_MAX_CYC,
  parameter int DOM_TO_CYC = CTMC_DOM_TO_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // system mode and mode command
  input wire ctmc_sys_t sys_mode,
  input wire ctmc_cmd_t mode_cmd,
  output ctmc_mode_t mode_status,
  output logic cmd_rejected,
  // controller pins
  input wire logic transmit_input_pin,
  output logic receive_output_pin,
  // bus side digital levels
  input wire logic bus_rx_dominant,
  output logic bus_drive_dominant,
  // fault flag
  output logic bus_fault_flag,
  input wire logic bus_fault_clear,
  // wake reporting
  output ctmc_wake_ev_t wake_ev
);

  localparam logic [CNT_W-1:0] EN_END = CNT_W'(EN_CYC - 1);
  localparam logic [CNT_W-1:0] TO_END = CNT_W'(DOM_TO_CYC - 1);

  typedef struct packed {
    logic tx_s1;
    logic tx_s2;
    logic rx_s1;
    logic rx_s2;
    ctmc_sys_t sys_prev;
    ctmc_mode_t mode;
    ctmc_tx_t tx_st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] dom_cnt;
    logic armed;
    logic wake_lat;
    logic fault;
    logic rej;
    logic drive;
    logic rxo;
    ctmc_wake_ev_t ev;
  } ctmc_state_t;

  ctmc_state_t r;
  ctmc_state_t n;
  logic tx_high;
  logic bus_dom;
  logic wake_hit;
  logic fs_entry;
  logic cmd_norm_ok;

  // which modes a command may select in each system mode
  function automatic logic mode_allowed(input ctmc_mode_t m, input ctmc_sys_t s);
    logic ns;
    ns = (s == CTMC_SYS_NORMAL) || (s == CTMC_SYS_STOP);
    case (m)
      CTMC_OFF: mode_allowed = 1'b1;
      CTMC_NORMAL: mode_allowed = ns;
      CTMC_RXONLY: mode_allowed = ns;
      CTMC_WAKE: mode_allowed = ns || (s == CTMC_SYS_SLEEP) || (s == CTMC_SYS_RESTART);
      default: mode_allowed = 1'b0;
    endcase
  endfunction : mode_allowed

  assign tx_high = r.tx_s2;
  assign bus_dom = r.rx_s2;
  assign fs_entry = (sys_mode == CTMC_SYS_FAILSAFE) && (r.sys_prev != CTMC_SYS_FAILSAFE);
  assign cmd_norm_ok = mode_cmd.valid && (mode_cmd.mode == CTMC_NORMAL) &&
                       ((sys_mode == CTMC_SYS_NORMAL) || (sys_mode == CTMC_SYS_STOP));

  // detector runs only when wake-capable and armed
  ctmc_wake_det #(
    .CNT_W(CNT_W),
    .MIN_CYC(WAKE_MIN_CYC),
    .MAX_CYC(WAKE_MAX_CYC)
  ) u_wake (
    .clock(clock),
    .reset_n(reset_n),
    .enable((r.mode == CTMC_WAKE) && r.armed),
    .bus_dom(bus_dom),
    .wake_hit(wake_hit)
  );

  always_comb begin
    n = r;
    // two-cycle sync keeps 50 cycles per bit at top rate
    n.tx_s1 = transmit_input_pin;
    n.tx_s2 = r.tx_s1;
    n.rx_s1 = bus_rx_dominant;
    n.rx_s2 = r.rx_s1;
    n.sys_prev = sys_mode;
    n.rej = 1'b0;
    n.ev = '0;

    // sleep wake asks for restart without interrupt
    if (wake_hit) begin
      n.wake_lat = 1'b1;
      n.armed = 1'b0;
      n.ev.wake_event = 1'b1;
      n.ev.restart_req = (sys_mode == CTMC_SYS_SLEEP) || (sys_mode == CTMC_SYS_FAILSAFE);
      n.ev.wake_irq = (sys_mode == CTMC_SYS_NORMAL) || (sys_mode == CTMC_SYS_STOP);
    end

    if (mode_cmd.valid) begin
      if (mode_allowed(mode_cmd.mode, sys_mode)) n.mode = mode_cmd.mode;
      else n.rej = 1'b1;
    end
    if (fs_entry) n.mode = CTMC_WAKE;
    // rearm on stop or fail-safe entry keeps rxd state
    if ((fs_entry || (sys_mode == CTMC_SYS_STOP && r.sys_prev != CTMC_SYS_STOP)) &&
        n.mode == CTMC_WAKE) begin
      n.armed = 1'b1;
    end
    // a real mode change clears the latch and rearms only when the new mode is wake
    if (n.mode != r.mode) begin
      n.wake_lat = 1'b0;
      n.armed = (n.mode == CTMC_WAKE);
    end

    if (n.mode != CTMC_NORMAL) begin
      n.tx_st = CTMC_TX_IDLE;
      n.cnt = '0;
      n.dom_cnt = '0;
    end else begin
      case (r.tx_st)
        CTMC_TX_IDLE: begin
          n.tx_st = CTMC_TX_SETTLE;
          n.cnt = '0;
        end
        CTMC_TX_SETTLE: begin
          // low input at settle end is held off
          if (r.cnt == EN_END) n.tx_st = tx_high ? CTMC_TX_ACTIVE : CTMC_TX_HOLD;
          else n.cnt = r.cnt + 1'b1;
        end
        CTMC_TX_HOLD: begin
          // start with the next recessive bit
          if (tx_high) n.tx_st = CTMC_TX_ACTIVE;
        end
        CTMC_TX_ACTIVE: begin
          if (tx_high) begin
            n.dom_cnt = '0;
          end else if (r.dom_cnt == TO_END) begin
            n.tx_st = CTMC_TX_TIMEOUT;
          end else begin
            n.dom_cnt = r.dom_cnt + 1'b1;
          end
        end
        CTMC_TX_TIMEOUT: begin
          // resume once input is recessive again
          if (tx_high) begin
            n.tx_st = CTMC_TX_ACTIVE;
            n.dom_cnt = '0;
          end
        end
        default: begin
          n.tx_st = CTMC_TX_IDLE;
          n.cnt = '0;
        end
      endcase
    end

    // set wins over a same-cycle clear
    if (bus_fault_clear) n.fault = 1'b0;
    if (r.tx_st == CTMC_TX_ACTIVE && n.tx_st == CTMC_TX_TIMEOUT) n.fault = 1'b1;

    n.drive = (n.tx_st == CTMC_TX_ACTIVE) && !tx_high;

    case (n.mode)
      CTMC_NORMAL: n.rxo = !bus_dom;
      CTMC_RXONLY: n.rxo = !bus_dom;
      CTMC_WAKE: n.rxo = !n.wake_lat;
      default: n.rxo = 1'b1;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      r <= '{tx_s1: 1'b1, tx_s2: 1'b1, rx_s1: 1'b0, rx_s2: 1'b0,
             sys_prev: CTMC_SYS_INIT, mode: CTMC_OFF, tx_st: CTMC_TX_IDLE,
             cnt: '0, dom_cnt: '0, armed: 1'b0, wake_lat: 1'b0, fault: 1'b0,
             rej: 1'b0, drive: 1'b0, rxo: 1'b1, ev: '0};
    end else begin
      r <= n;
    end
  end

  assign mode_status = r.mode;
  assign cmd_rejected = r.rej;
  assign bus_drive_dominant = r.drive;
  assign receive_output_pin = r.rxo;
  assign bus_fault_flag = r.fault;
  assign wake_ev = r.ev;

  off_no_wake_a: assert property (@(posedge clock) disable iff (!reset_n)
    (mode_status != CTMC_WAKE) && ($past(mode_status) != CTMC_WAKE) |=> !wake_ev.wake_event)
    else $error("wake reported outside wake-capable mode");
  normal_entry_a: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(mode_status == CTMC_NORMAL) |-> $past(cmd_norm_ok))
    else $error("normal mode entered without a legal command");
  settle_quiet_a: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(mode_status == CTMC_NORMAL) |-> !bus_drive_dominant [*8])
    else $error("driver active during enable settling");
  hold_quiet_a: assert property (@(posedge clock) disable iff (!reset_n)
    (r.tx_st == CTMC_TX_HOLD) |-> !bus_drive_dominant)
    else $error("driver active while holding off");
  drive_cause_a: assert property (@(posedge clock) disable iff (!reset_n)
    bus_drive_dominant |-> (mode_status == CTMC_NORMAL) && !$past(tx_high))
    else $error("dominant drive without low input in normal mode");
  rx_follow_a: assert property (@(posedge clock) disable iff (!reset_n)
    (mode_status == CTMC_RXONLY) && $past(mode_status == CTMC_RXONLY)
      |-> (receive_output_pin == !$past(bus_dom)) && !bus_drive_dominant)
    else $error("receive-only output does not follow bus");
  wake_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
    (mode_status == CTMC_WAKE) && !receive_output_pin
      |=> (mode_status != CTMC_WAKE) || !receive_output_pin)
    else $error("wake indication released without a mode change");
  failsafe_wake_a: assert property (@(posedge clock) disable iff (!reset_n)
    fs_entry |=> mode_status == CTMC_WAKE)
    else $error("fail-safe entry did not force wake-capable mode");
  sleep_restart_a: assert property (@(posedge clock) disable iff (!reset_n)
    wake_ev.wake_event && ($past(sys_mode) == CTMC_SYS_SLEEP)
      |-> wake_ev.restart_req && !wake_ev.wake_irq)
    else $error("sleep wake did not request restart quietly");
  timeout_fault_a: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(bus_fault_flag) && !$past(bus_fault_clear)
      |-> !bus_drive_dominant && (mode_status == CTMC_NORMAL))
    else $error("timeout fault without driver release");

  wake_seen_c: cover property (@(posedge clock) disable iff (!reset_n) wake_ev.wake_event);
  hold_seen_c: cover property (@(posedge clock) disable iff (!reset_n)
    r.tx_st == CTMC_TX_HOLD ##[1:20] bus_drive_dominant);
  timeout_seen_c: cover property (@(posedge clock) disable iff (!reset_n) $rose(bus_fault_flag));
  reject_seen_c: cover property (@(posedge clock) disable iff (!reset_n) cmd_rejected);

endmodule : ctmc_transceiver

// ==== design/ctmc_pkg.sv ====
package ctmc_pkg;

  // transceiver mode encoding as seen by software; gray order off-wake-rxonly-normal
  typedef enum logic [1:0] {
    CTMC_OFF    = 2'h0,
    CTMC_WAKE   = 2'h1,
    CTMC_RXONLY = 2'h3,
    CTMC_NORMAL = 2'h2
  } ctmc_mode_t;

  // system mode of the surrounding chip, driven by its own state machine
  typedef enum logic [2:0] {
    CTMC_SYS_INIT     = 3'h0,
    CTMC_SYS_NORMAL   = 3'h1,
    CTMC_SYS_STOP     = 3'h3,
    CTMC_SYS_SLEEP    = 3'h2,
    CTMC_SYS_RESTART  = 3'h6,
    CTMC_SYS_FAILSAFE = 3'h7
  } ctmc_sys_t;

  // transmit path states; gray along idle-settle-hold-active-timeout
  typedef enum logic [2:0] {
    CTMC_TX_IDLE    = 3'h0,
    CTMC_TX_SETTLE  = 3'h1,
    CTMC_TX_HOLD    = 3'h3,
    CTMC_TX_ACTIVE  = 3'h2,
    CTMC_TX_TIMEOUT = 3'h6
  } ctmc_tx_t;

  // wake pattern phases
  typedef enum logic [1:0] {
    CTMC_WD_IDLE = 2'h0,
    CTMC_WD_DOM1 = 2'h1,
    CTMC_WD_REC  = 2'h3,
    CTMC_WD_DOM2 = 2'h2
  } ctmc_wph_t;

  // mode command from the spi register block
  typedef struct packed {
    logic valid;
    ctmc_mode_t mode;
  } ctmc_cmd_t;

  // wake reporting towards the system state machine
  typedef struct packed {
    logic wake_event;
    logic wake_irq;
    logic restart_req;
  } ctmc_wake_ev_t;

  localparam int CTMC_CLK_MHZ = 100;
  localparam int CTMC_SYNC_STAGES = 2;
  // highest signalling rate in kbaud and the bit time it implies
  localparam int CTMC_MAX_KBAUD = 2000;
  localparam int CTMC_BIT_MIN_NS = 1000000 / CTMC_MAX_KBAUD;

  localparam int CTMC_EN_TIME_NS = 10000;
  localparam int CTMC_WAKE_MIN_NS = 500;
  localparam int CTMC_WAKE_MAX_NS = 1000000;
  localparam int CTMC_DOM_TO_NS = 1000000;

  // least times round up, longest times round down
  localparam int CTMC_EN_CYC = (CTMC_EN_TIME_NS * CTMC_CLK_MHZ + 999) / 1000;
  localparam int CTMC_WAKE_MIN_CYC = (CTMC_WAKE_MIN_NS * CTMC_CLK_MHZ + 999) / 1000;
  localparam int CTMC_WAKE_MAX_CYC = (CTMC_WAKE_MAX_NS * CTMC_CLK_MHZ) / 1000;
  localparam int CTMC_DOM_TO_CYC = (CTMC_DOM_TO_NS * CTMC_CLK_MHZ + 999) / 1000;
  localparam int CTMC_CNT_W = 20;

endpackage : ctmc_pkg

// ==== design/ctmc_wake_det.sv ====
`timescale 1ns/1ps
module ctmc_wake_det
  import ctmc_pkg::*;
#(
  parameter int CNT_W = CTMC_CNT_W,
  parameter int MIN_CYC = CTMC_WAKE_MIN_CYC,
  parameter int MAX_CYC = CTMC_WAKE_MAX_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // synchronised bus level and arming
  input wire logic enable,
  input wire logic bus_dom,
  // one-cycle pulse when a full pattern is seen
  output logic wake_hit
);

  localparam logic [CNT_W-1:0] MIN_END = CNT_W'(MIN_CYC);
  localparam logic [CNT_W-1:0] MAX_END = CNT_W'(MAX_CYC - 1);

  typedef struct packed {
    ctmc_wph_t ph;
    logic [CNT_W-1:0] cnt;
    logic prev;
    logic hit;
  } ctmc_wd_state_t;

  ctmc_wd_state_t r;
  ctmc_wd_state_t n;

  // cnt holds the current phase length minus one
  always_comb begin
    n = r;
    n.prev = bus_dom;
    n.hit = 1'b0;
    if (!enable) begin
      n.ph = CTMC_WD_IDLE;
      n.cnt = '0;
    end else begin
      case (r.ph)
        CTMC_WD_IDLE: begin
          // a search only starts on a fresh dominant edge
          if (bus_dom && !r.prev) begin
            n.ph = CTMC_WD_DOM1;
            n.cnt = '0;
          end
        end
        CTMC_WD_DOM1: begin
          if (bus_dom) begin
            if (r.cnt == MAX_END) n.ph = CTMC_WD_IDLE;
            else n.cnt = r.cnt + 1'b1;
          end else begin
            n.ph = (r.cnt >= MIN_END) ? CTMC_WD_REC : CTMC_WD_IDLE;
            n.cnt = '0;
          end
        end
        CTMC_WD_REC: begin
          if (!bus_dom) begin
            if (r.cnt == MAX_END) n.ph = CTMC_WD_IDLE;
            else n.cnt = r.cnt + 1'b1;
          end else begin
            // too short a gap restarts here
            n.ph = (r.cnt >= MIN_END) ? CTMC_WD_DOM2 : CTMC_WD_DOM1;
            n.cnt = '0;
          end
        end
        CTMC_WD_DOM2: begin
          if (bus_dom) begin
            if (r.cnt >= MIN_END) begin
              n.hit = 1'b1;
              n.ph = CTMC_WD_IDLE;
            end else begin
              n.cnt = r.cnt + 1'b1;
            end
          end else begin
            n.ph = CTMC_WD_IDLE;
            n.cnt = '0;
          end
        end
        default: begin
          n.ph = CTMC_WD_IDLE;
          n.cnt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) r <= '{ph: CTMC_WD_IDLE, cnt: '0, prev: 1'b0, hit: 1'b0};
    else r <= n;
  end

  assign wake_hit = r.hit;

  hit_after_dom_a: assert property (@(posedge clock) disable iff (!reset_n)
    wake_hit |-> $past(bus_dom, 1) && $past(bus_dom, 2))
    else $error("wake hit without a dominant tail");
  phase_bound_a: assert property (@(posedge clock) disable iff (!reset_n)
    r.ph != CTMC_WD_IDLE |-> r.cnt <= MAX_END)
    else $error("wake phase counter past its limit");

endmodule : ctmc_wake_det

// ==== sim/ctmc_ptn_model.sv ====
`timescale 1ns/1ps
module ctmc_ptn_model #(
  parameter int EN_CYC = 20
) (
  // clock
  input wire logic clock,
  // device side
  input wire logic bus_drive_dominant,
  output logic transmit_input_pin,
  output logic bus_rx_dominant
);
  logic tx_r = 1'b1;
  logic node_dom_r = 1'b0;
  // wired bus: any driver makes it dominant
  assign bus_rx_dominant = node_dom_r | bus_drive_dominant;
  assign transmit_input_pin = tx_r;
  task automatic drive(input logic tx, input logic node);
    tx_r = tx;
    node_dom_r = node;
  endtask : drive
  task automatic settle();
    tx_r = 1'b1;
    repeat (EN_CYC + 4) @(posedge clock);
    #1;
  endtask : settle
endmodule : ctmc_ptn_model

// ==== sim/tb.sv ====
`timescale 1ns/1ps
module tb;
  import ctmc_pkg::*;
  localparam int EN = 20;
  localparam int WMIN = 5;
  localparam int WMAX = 40;
  localparam int DTO = 60;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  ctmc_sys_t sys_mode = CTMC_SYS_INIT;
  ctmc_cmd_t mode_cmd = '0;
  logic bus_fault_clear = 1'b0;
  ctmc_mode_t mode_status;
  logic cmd_rejected;
  logic tx_pin;
  logic rxd;
  logic bus_dom;
  logic drv;
  logic fault;
  ctmc_wake_ev_t wake_ev;
  int n_fail = 0;
  int tests_run = 0;
  int n_we = 0;
  int n_irq = 0;
  int n_rst = 0;
  int b_we = 0;
  int b_irq = 0;
  int b_rst = 0;

  always #5 clock = ~clock;

  // pulses are one cycle wide; counting on the falling edge avoids a race
  always @(negedge clock) begin
    n_we += int'(wake_ev.wake_event);
    n_irq += int'(wake_ev.wake_irq);
    n_rst += int'(wake_ev.restart_req);
  end

  ctmc_transceiver #(
    .EN_CYC(EN), .WAKE_MIN_CYC(WMIN), .WAKE_MAX_CYC(WMAX), .DOM_TO_CYC(DTO)
  ) i_dut (
    .clock(clock), .reset_n(reset_n), .sys_mode(sys_mode), .mode_cmd(mode_cmd),
    .mode_status(mode_status), .cmd_rejected(cmd_rejected),
    .transmit_input_pin(tx_pin), .receive_output_pin(rxd),
    .bus_rx_dominant(bus_dom), .bus_drive_dominant(drv),
    .bus_fault_flag(fault), .bus_fault_clear(bus_fault_clear), .wake_ev(wake_ev)
  );

  ctmc_ptn_model #(.EN_CYC(EN)) i_ptn (
    .clock(clock), .bus_drive_dominant(drv),
    .transmit_input_pin(tx_pin), .bus_rx_dominant(bus_dom)
  );

  task automatic summarize();
    $display("checks %0d, failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : wait_cyc

  task automatic phase(input logic tx, input logic node, input int n);
    i_ptn.drive(tx, node);
    wait_cyc(n);
  endtask : phase

  task automatic cmd_chk(input ctmc_mode_t m, input logic rej, input ctmc_mode_t exp);
    mode_cmd = '{valid: 1'b1, mode: m};
    wait_cyc(1);
    mode_cmd = '0;
    chk_bit(cmd_rejected, rej);
    chk_val(8'(mode_status), 8'(exp));
    wait_cyc(1);
  endtask : cmd_chk

  task automatic wake_chk(input int we, input int irq, input int rst);
    chk_val(8'(n_we - b_we), 8'(we));
    chk_val(8'(n_irq - b_irq), 8'(irq));
    chk_val(8'(n_rst - b_rst), 8'(rst));
    b_we = n_we;
    b_irq = n_irq;
    b_rst = n_rst;
  endtask : wake_chk

  // dominant, recessive of the given length, dominant, then idle
  task automatic bus_wake_pattern(input int rec);
    phase(1'b1, 1'b1, WMIN + 5);
    phase(1'b1, 1'b0, rec);
    phase(1'b1, 1'b1, WMIN + 5);
    phase(1'b1, 1'b0, 10);
  endtask : bus_wake_pattern

  task automatic t_reset();
    chk_val(8'(mode_status), 8'(CTMC_OFF));
    chk_bit(rxd, 1'b1);
    chk_bit(drv, 1'b0);
  endtask : t_reset

  task automatic t_perm();
    ctmc_sys_t sl [5] = '{CTMC_SYS_INIT, CTMC_SYS_NORMAL, CTMC_SYS_STOP, CTMC_SYS_SLEEP,
                          CTMC_SYS_RESTART};
    ctmc_mode_t m;
    logic ok;
    for (int s = 0; s < 5; s++) begin
      for (int i = 0; i < 4; i++) begin
        m = ctmc_mode_t'(i[1:0]);
        ok = (m == CTMC_OFF) || (m == CTMC_WAKE && s > 0) ||
             ((m == CTMC_NORMAL || m == CTMC_RXONLY) && (s == 1 || s == 2));
        sys_mode = sl[s];
        cmd_chk(CTMC_OFF, 1'b0, CTMC_OFF);
        cmd_chk(m, !ok, ok ? m : CTMC_OFF);
      end
    end
  endtask : t_perm

  task automatic t_normal();
    sys_mode = CTMC_SYS_NORMAL;
    phase(1'b0, 1'b0, 1);
    cmd_chk(CTMC_NORMAL, 1'b0, CTMC_NORMAL);
    wait_cyc(EN + 6);
    chk_bit(drv, 1'b0);
    phase(1'b1, 1'b0, 4);
    phase(1'b0, 1'b0, 8);
    chk_bit(drv, 1'b1);
    chk_bit(rxd, 1'b0);
    // bit time of 50 cycles is the fastest rate
    for (int i = 1; i < 5; i++) begin
      phase(i[0], 1'b0, 50);
      chk_bit(drv, !i[0]);
      chk_bit(rxd, i[0]);
    end
    cmd_chk(CTMC_OFF, 1'b0, CTMC_OFF);
    phase(1'b1, 1'b0, 1);
    cmd_chk(CTMC_NORMAL, 1'b0, CTMC_NORMAL);
    i_ptn.settle();
    phase(1'b0, 1'b0, DTO - 5);
    chk_bit(drv, 1'b1);
    phase(1'b0, 1'b0, 13);
    chk_bit(drv, 1'b0);
    chk_bit(fault, 1'b1);
    chk_val(8'(mode_status), 8'(CTMC_NORMAL));
    phase(1'b1, 1'b0, 4);
    phase(1'b0, 1'b0, 8);
    chk_bit(drv, 1'b1);
    chk_bit(fault, 1'b1);
    phase(1'b1, 1'b0, 2);
    bus_fault_clear = 1'b1;
    wait_cyc(1);
    bus_fault_clear = 1'b0;
    wait_cyc(2);
    chk_bit(fault, 1'b0);
  endtask : t_normal

  task automatic t_rxonly();
    cmd_chk(CTMC_RXONLY, 1'b0, CTMC_RXONLY);
    phase(1'b0, 1'b1, 8);
    chk_bit(drv, 1'b0);
    chk_bit(rxd, 1'b0);
    phase(1'b0, 1'b0, 8);
    chk_bit(rxd, 1'b1);
    phase(1'b1, 1'b0, 1);
  endtask : t_rxonly

  task automatic t_wake();
    sys_mode = CTMC_SYS_SLEEP;
    cmd_chk(CTMC_WAKE, 1'b0, CTMC_WAKE);
    bus_wake_pattern(WMIN + 5);
    wake_chk(1, 0, 1);
    chk_bit(rxd, 1'b0);
    bus_wake_pattern(WMIN + 5);
    wake_chk(0, 0, 0);
    chk_bit(rxd, 1'b0);
    cmd_chk(CTMC_OFF, 1'b0, CTMC_OFF);
    wait_cyc(2);
    chk_bit(rxd, 1'b1);
    bus_wake_pattern(WMIN + 5);
    wake_chk(0, 0, 0);
    sys_mode = CTMC_SYS_NORMAL;
    cmd_chk(CTMC_WAKE, 1'b0, CTMC_WAKE);
    bus_wake_pattern(WMAX + 10);
    wake_chk(0, 0, 0);
    phase(1'b1, 1'b1, WMIN + 5);
    phase(1'b1, 1'b0, 10);
    wake_chk(1, 1, 0);
    cmd_chk(CTMC_NORMAL, 1'b0, CTMC_NORMAL);
    i_ptn.settle();
    phase(1'b0, 1'b0, 8);
    chk_bit(drv, 1'b1);
    phase(1'b1, 1'b0, 4);
  endtask : t_wake

  task automatic t_fail();
    sys_mode = CTMC_SYS_FAILSAFE;
    wait_cyc(3);
    chk_val(8'(mode_status), 8'(CTMC_WAKE));
    chk_bit(drv, 1'b0);
    cmd_chk(CTMC_OFF, 1'b0, CTMC_OFF);
  endtask : t_fail

  // the whole run needs well under 5000 cycles
  initial begin
    #200000;
    n_fail++;
    summarize();
  end

  initial begin
    repeat (8) @(posedge clock);
    #1;
    reset_n = 1'b1;
    wait_cyc(1);
    t_reset();
    t_perm();
    t_normal();
    t_rxonly();
    t_wake();
    t_fail();
    summarize();
  end
endmodule : tb
